// [core/blm_pkg.sv]
// constants and types shared by the burner lockout monitor
// Behaviour
// - flame present in stand-by or post-purge for 25 s causes lockout
// - false flame during pre-purge for 1 s causes lockout
// - no flame 3 s after gas valve energised in safety time: lockout
// - flame loss in operation recycles; fourth loss after 3 recycles locks out
// - fan motor fault or parameter memory fault locks out at once
// - first stage valve internal fault locks out at once
// - second stage valve internal fault locks out at once, own pulse code
// - air switch not closed 15 s after heat request or recycle: lockout
// - air loss in late purge, safety time or operation: lockout after 1 s
// - in lockout the reset LED blinks a pulse count unique per fault
// - lockout holds until the operator presses the reset button
// - each lockout type is logged, keeping the ten most recent
package blm_pkg;

  // sequencer phase reported to the monitor
  typedef enum logic [2:0] {
    PH_STANDBY,
    PH_AIR_IDLE,
    PH_AIR_WAIT,
    PH_PREPURGE,
    PH_PURGE_END,
    PH_SAFETY,
    PH_RUN,
    PH_POSTPURGE
  } blm_phase_t;

  // lockout causes; the value is also the LED pulse count
  typedef enum logic [3:0] {
    LK_NONE,
    LK_FLAME_STBY,
    LK_FLAME_PRE,
    LK_NO_FLAME,
    LK_FLAME_LOSS,
    LK_FAN,
    LK_VALVE1,
    LK_MEMORY,
    LK_AIR_NOCLOSE,
    LK_AIR_LOST,
    LK_AIR_STUCK,
    LK_VALVE2
  } blm_lock_t;

  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1000000;
  localparam int TICK_CYC      = MS_NS / CLK_PERIOD_NS;

  localparam int FLAME_STBY_MS = 25000;
  localparam int FLAME_PRE_MS  = 1000;
  localparam int NO_FLAME_MS   = 3000;
  localparam int AIR_CLOSE_MS  = 15000;
  localparam int AIR_LOST_MS   = 1000;
  localparam int AIR_STUCK_MS  = 120000;
  localparam int RECYCLE_MAX   = 3;
  localparam int LOG_DEPTH     = 10;

  localparam int LED_ON_MS     = 300;
  localparam int LED_OFF_MS    = 300;
  localparam int LED_GAP_MS    = 2000;

endpackage : blm_pkg

// [core/blm_led_code.sv]
// reset-button LED pulse code generator
`timescale 1ns/1ns
module blm_led_code #(
  parameter int ON_MS  = blm_pkg::LED_ON_MS,
  parameter int OFF_MS = blm_pkg::LED_OFF_MS,
  parameter int GAP_MS = blm_pkg::LED_GAP_MS
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // control
  input  wire logic       i_en,
  input  wire logic [3:0] i_code,
  input  wire logic       i_tick,
  // lamp
  output logic            o_led
);

  typedef enum logic [1:0] {LS_IDLE, LS_ON, LS_OFF, LS_GAP} blm_ls_t;

  typedef struct packed {
    blm_ls_t     st;
    logic [15:0] ms;
    logic [3:0]  n;
    logic        led;
  } blm_led_st_t;

  blm_led_st_t q, d;

  always_comb begin
    d = q;
    if (!i_en) begin
      d.st = LS_IDLE;
    end else if (i_tick) begin
      d.ms = q.ms + 16'h0001;
      case (q.st)
        LS_IDLE: begin
          d.st = LS_ON;
          d.ms = '0;
          d.n  = 4'h1;
        end
        LS_ON: if (q.ms >= 16'(ON_MS - 1)) begin
          d.st = LS_OFF;
          d.ms = '0;
        end
        LS_OFF: if (q.ms >= 16'(OFF_MS - 1)) begin
          d.ms = '0;
          d.st = (q.n >= i_code) ? LS_GAP : LS_ON;
          d.n  = q.n + 4'h1;
        end
        LS_GAP: if (q.ms >= 16'(GAP_MS - 1)) begin
          d.st = LS_ON;
          d.ms = '0;
          d.n  = 4'h1;
        end
        default: d.st = LS_IDLE;
      endcase
    end
    d.led = i_en && (d.st == LS_ON);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_led = q.led;

  a_led_dark: assert property (
    @(posedge i_clk) disable iff (!i_rst_n) !i_en |=> !o_led)
    else $error("led lit outside lockout");

endmodule : blm_led_code

// [core/blm_monitor.sv]
// burner lockout monitor: fault timing, lockout latch, log and LED
`timescale 1ns/1ns
module blm_monitor #(
  parameter int TICK_CYC      = blm_pkg::TICK_CYC,
  parameter int FLAME_STBY_MS = blm_pkg::FLAME_STBY_MS,
  parameter int FLAME_PRE_MS  = blm_pkg::FLAME_PRE_MS,
  parameter int NO_FLAME_MS   = blm_pkg::NO_FLAME_MS,
  parameter int AIR_CLOSE_MS  = blm_pkg::AIR_CLOSE_MS,
  parameter int AIR_LOST_MS   = blm_pkg::AIR_LOST_MS,
  parameter int AIR_STUCK_MS  = blm_pkg::AIR_STUCK_MS,
  parameter int LOG_N         = blm_pkg::LOG_DEPTH
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // sequencer state and requests
  input  wire logic [2:0] i_phase,
  input  wire logic       i_heat_req,
  input  wire logic       i_gas1_req,
  input  wire logic       i_gas2_req,
  input  wire logic       i_ign_req,
  // field sensors and fault lines
  input  wire logic       i_flame,
  input  wire logic       i_air_closed,
  input  wire logic       i_fan_fault,
  input  wire logic       i_mem_fault,
  input  wire logic       i_valve1_fault,
  input  wire logic       i_valve2_fault,
  // operator
  input  wire logic       i_reset_btn,
  input  wire logic [3:0] i_log_sel,
  // actuators
  output logic            o_gas1,
  output logic            o_gas2,
  output logic            o_ign,
  output logic            o_heat_ok,
  // status
  output logic            o_lockout,
  output logic [3:0]      o_lock_type,
  output logic            o_recycle,
  output logic [3:0]      o_log_type,
  output logic            o_led
);

  localparam int TW  = 17;
  localparam int TKW = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic                  locked;
    blm_pkg::blm_lock_t    ltype;
    blm_pkg::blm_lock_t    cand;
    logic [TW-1:0]         tmr;
    logic [TKW-1:0]        tick;
    logic [1:0]            rcy;
    logic                  flame;
    logic                  btn;
    logic [LOG_N-1:0][3:0] log;
    logic [3:0]            log_out;
    logic                  gas1;
    logic                  gas2;
    logic                  ign;
    logic                  recycle;
  } blm_st_t;

  blm_st_t            q, d;
  logic [1:0]         rst_sync;
  logic               rst_n;
  logic               tick_hit;
  logic               press;
  logic [1:0]         rcy_cur;
  blm_pkg::blm_lock_t cand;
  blm_pkg::blm_lock_t hit;
  logic [TW-1:0]      lim;
  blm_pkg::blm_phase_t ph;

  // reset released through two flops so all state leaves reset together
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_comb begin
    ph       = blm_pkg::blm_phase_t'(i_phase);
    d        = q;
    tick_hit = (q.tick == TKW'(TICK_CYC - 1));
    d.tick   = tick_hit ? '0 : q.tick + TKW'(1);
    press    = i_reset_btn && !q.btn;
    rcy_cur  = q.locked ? 2'h0 : q.rcy;
    d.btn    = i_reset_btn;
    d.flame  = i_flame;
    d.recycle = 1'b0;
    hit      = blm_pkg::LK_NONE;
    cand     = blm_pkg::LK_NONE;
    lim      = '0;
    // pending timed fault; only one can be building at a time
    if ((ph == blm_pkg::PH_STANDBY || ph == blm_pkg::PH_POSTPURGE)
        && i_flame) begin
      cand = blm_pkg::LK_FLAME_STBY;
      lim  = TW'(FLAME_STBY_MS);
    end else if ((ph == blm_pkg::PH_PREPURGE || ph == blm_pkg::PH_PURGE_END)
                 && i_flame) begin
      cand = blm_pkg::LK_FLAME_PRE;
      lim  = TW'(FLAME_PRE_MS);
    end else if (ph == blm_pkg::PH_AIR_IDLE && i_air_closed) begin
      cand = blm_pkg::LK_AIR_STUCK;
      lim  = TW'(AIR_STUCK_MS);
    end else if (ph == blm_pkg::PH_AIR_WAIT && !i_air_closed) begin
      cand = blm_pkg::LK_AIR_NOCLOSE;
      lim  = TW'(AIR_CLOSE_MS);
    end else if ((ph == blm_pkg::PH_PURGE_END || ph == blm_pkg::PH_SAFETY
                  || ph == blm_pkg::PH_RUN) && !i_air_closed) begin
      cand = blm_pkg::LK_AIR_LOST;
      lim  = TW'(AIR_LOST_MS);
    end else if (ph == blm_pkg::PH_SAFETY && i_gas1_req && !i_flame) begin
      cand = blm_pkg::LK_NO_FLAME;
      lim  = TW'(NO_FLAME_MS);
    end
    if (q.locked && !press) begin
      d.cand = blm_pkg::LK_NONE;
      d.tmr  = '0;
    end else begin
      // a fault seen in the release cycle wins over the press
      if (q.locked) begin
        d.locked = 1'b0;
        d.rcy    = 2'h0;
      end
      if (i_fan_fault) begin
        hit = blm_pkg::LK_FAN;
      end else if (i_mem_fault) begin
        hit = blm_pkg::LK_MEMORY;
      end else if (i_valve1_fault) begin
        hit = blm_pkg::LK_VALVE1;
      end else if (i_valve2_fault) begin
        hit = blm_pkg::LK_VALVE2;
      end else if (ph == blm_pkg::PH_RUN && q.flame && !i_flame) begin
        if (rcy_cur == 2'(blm_pkg::RECYCLE_MAX)) begin
          hit = blm_pkg::LK_FLAME_LOSS;
        end else begin
          d.rcy     = rcy_cur + 2'h1;
          d.recycle = 1'b1;
        end
      end else if (cand != blm_pkg::LK_NONE && q.cand == cand
                   && q.tmr >= lim) begin
        hit = cand;
      end
      // a changed cause restarts the persistence count
      d.cand = cand;
      if (cand != q.cand) begin
        // restart the ms prescaler too, so no cause locks out early
        d.tmr  = '0;
        d.tick = '0;
      end else if (tick_hit && q.tmr < lim) begin
        d.tmr = q.tmr + TW'(1);
      end
      if (ph == blm_pkg::PH_STANDBY && !i_heat_req) begin
        d.rcy = 2'h0;
      end
      if (hit != blm_pkg::LK_NONE) begin
        d.locked = 1'b1;
        d.ltype  = hit;
        d.log    = {q.log[LOG_N-2:0], hit};
      end
    end
    d.log_out = (i_log_sel < 4'(LOG_N)) ? q.log[i_log_sel] : 4'h0;
    d.gas1    = i_gas1_req && !d.locked;
    d.gas2    = i_gas2_req && !d.locked;
    d.ign     = i_ign_req && !d.locked;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  blm_led_code u_led (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_en    (q.locked),
    .i_code  (q.ltype),
    .i_tick  (tick_hit),
    .o_led   (o_led)
  );

  assign o_gas1      = q.gas1;
  assign o_gas2      = q.gas2;
  assign o_ign       = q.ign;
  assign o_heat_ok   = !q.locked;
  assign o_lockout   = q.locked;
  assign o_lock_type = q.ltype;
  assign o_recycle   = q.recycle;
  assign o_log_type  = q.log_out;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_fan_immediate: assert property (
    !q.locked && i_fan_fault |=> q.locked && q.ltype == blm_pkg::LK_FAN)
    else $error("fan fault did not lock out next cycle");

  a_mem_immediate: assert property (
    !q.locked && !i_fan_fault && i_mem_fault
    |=> q.locked && q.ltype == blm_pkg::LK_MEMORY)
    else $error("memory fault did not lock out next cycle");

  a_valve1_lock: assert property (
    !q.locked && !i_fan_fault && !i_mem_fault && i_valve1_fault
    |=> q.locked && q.ltype == blm_pkg::LK_VALVE1)
    else $error("stage one valve fault not latched");

  a_valve2_code: assert property (
    !q.locked && !i_fan_fault && !i_mem_fault && !i_valve1_fault
    && i_valve2_fault |=> q.locked && q.ltype == blm_pkg::LK_VALVE2)
    else $error("stage two valve fault not latched with own code");

  a_lock_holds: assert property (
    q.locked && !(i_reset_btn && !q.btn) |=> q.locked && $stable(q.ltype))
    else $error("lockout left without reset press");

  a_outputs_dead: assert property (
    q.locked |-> !o_gas1 && !o_gas2 && !o_ign && !o_heat_ok)
    else $error("actuator on during lockout");

  a_log_newest: assert property (
    $rose(q.locked) |-> q.log[0] == q.ltype)
    else $error("lockout not logged as newest entry");

  a_fourth_loss: assert property (
    !q.locked && ph == blm_pkg::PH_RUN && q.flame && !i_flame
    && !i_fan_fault && !i_mem_fault && !i_valve1_fault && !i_valve2_fault
    && q.rcy == 2'(blm_pkg::RECYCLE_MAX)
    |=> q.locked && q.ltype == blm_pkg::LK_FLAME_LOSS)
    else $error("flame loss after recycles did not lock out");

  a_timer_bound: assert property (
    q.cand != blm_pkg::LK_NONE && !q.locked |-> q.tmr <= lim || q.cand != cand)
    else $error("persistence count overran its limit");

endmodule : blm_monitor

// [sim/blm_field_model.sv]
// field side model: flame probe, air switch, fault lines, reset button
`timescale 1ns/1ns
module blm_field_model (
  // clock
  input  wire logic       i_clk,
  // commands from the bench
  input  wire logic       i_flame_cmd,
  input  wire logic       i_air_cmd,
  input  wire logic [3:0] i_fault_cmd,
  input  wire logic       i_press,
  // lines toward the monitor
  output logic            o_flame,
  output logic            o_air_closed,
  output logic [3:0]      o_fault,
  output logic            o_reset_btn
);
  logic [1:0] hold_q;

  initial {o_flame, o_air_closed, o_fault, o_reset_btn, hold_q} = '0;

  // sensors settle one clock late, so the monitor never sees bench edges
  always @(posedge i_clk) begin
    o_flame      <= i_flame_cmd;
    o_air_closed <= i_air_cmd;
    o_fault      <= i_fault_cmd;
    // a hand press lasts at least two clocks, never a single-cycle glitch
    hold_q       <= i_press ? 2'h3 : hold_q >> 1;
    o_reset_btn  <= hold_q[0];
  end
endmodule : blm_field_model

// [sim/tb_burner_lockout_monitor.sv]
// self-checking bench for the burner lockout monitor
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s expected %0h seen %0h", nm, e, g); \
  end end
module tb_burner_lockout_monitor;
  // shortened tick and fault times keep the run brief
  localparam int TK = 4, F_STBY = 6, F_PRE = 2, NO_FL = 4;
  localparam int A_CL = 5, A_LO = 2, A_ST = 8;
  typedef struct {
    logic [2:0] ph;
    logic       fl, air, rq;
    logic [3:0] flt;
    int         lim;
    logic [3:0] code;
  } blm_row_t;
  blm_row_t rows [12] = '{
    '{3'h0, 1, 0, 0, 4'h0, F_STBY, 4'h1},
    '{3'h3, 1, 1, 1, 4'h0, F_PRE,  4'h2},
    '{3'h5, 0, 1, 1, 4'h0, NO_FL,  4'h3},
    '{3'h0, 0, 0, 0, 4'h1, 0,      4'h5},
    '{3'h0, 0, 0, 0, 4'h2, 0,      4'h7},
    '{3'h0, 0, 0, 0, 4'h4, 0,      4'h6},
    '{3'h0, 0, 0, 0, 4'h8, 0,      4'hb},
    '{3'h2, 0, 0, 0, 4'h0, A_CL,   4'h8},
    '{3'h6, 1, 0, 1, 4'h0, A_LO,   4'h9},
    '{3'h1, 0, 1, 0, 4'h0, A_ST,   4'ha},
    '{3'h4, 1, 1, 0, 4'h0, F_PRE,  4'h2},
    '{3'h7, 1, 0, 0, 4'h0, F_STBY, 4'h1}};
  logic       clk = 0, nrst = 0, heat = 0, req = 0, press = 0;
  logic       flame_cmd = 0, air_cmd = 0, seen, prev;
  logic [2:0] phase = '0;
  logic [3:0] fault_cmd = '0, sel = '0, flt, ltype, log_t, e;
  logic       flame, air, btn, gas1, gas2, ign, heat_ok, lock, recyc, led;
  int         miscompares = 0, total_checks = 0, cycles = 0, n;

  blm_monitor #(.TICK_CYC(TK), .FLAME_STBY_MS(F_STBY), .FLAME_PRE_MS(F_PRE),
    .NO_FLAME_MS(NO_FL), .AIR_CLOSE_MS(A_CL), .AIR_LOST_MS(A_LO),
    .AIR_STUCK_MS(A_ST)) u_dut (
    .i_clk(clk), .i_nrst(nrst), .i_phase(phase), .i_heat_req(heat),
    .i_gas1_req(req), .i_gas2_req(req), .i_ign_req(req), .i_flame(flame),
    .i_air_closed(air), .i_fan_fault(flt[0]), .i_mem_fault(flt[1]),
    .i_valve1_fault(flt[2]), .i_valve2_fault(flt[3]), .i_reset_btn(btn),
    .i_log_sel(sel), .o_gas1(gas1), .o_gas2(gas2), .o_ign(ign),
    .o_heat_ok(heat_ok), .o_lockout(lock), .o_lock_type(ltype),
    .o_recycle(recyc), .o_log_type(log_t), .o_led(led));

  blm_field_model u_field (.i_clk(clk), .i_flame_cmd(flame_cmd),
    .i_air_cmd(air_cmd), .i_fault_cmd(fault_cmd), .i_press(press),
    .o_flame(flame), .o_air_closed(air), .o_fault(flt), .o_reset_btn(btn));

  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // v packs heat, flame, air, requests and the four fault lines
  task automatic drive(input logic [2:0] p, input logic [7:0] v);
    @(posedge clk);
    {phase, heat, flame_cmd, air_cmd, req, fault_cmd} <= {p, v};
  endtask : drive

  task automatic wait_lock(input int m);
    n = 0;
    while (lock !== 1'b1 && n < m) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_lock

  task automatic clear_lock();
    drive(3'h0, 8'h00);
    repeat (3) @(posedge clk);
    #1 `CHK("held", 1'b1, lock)
    @(posedge clk);
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    #1 n = 0;
    while (lock !== 1'b0 && n < 5) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("released", 1'b0, lock)
  endtask : clear_lock

  task automatic run_row(input blm_row_t r);
    drive(r.ph, {1'b1, r.fl, r.air, r.rq, r.flt});
    repeat (2) @(posedge clk);
    #1;
    if (r.lim > 0) begin
      `CHK("gas_open", {3{r.rq}}, {gas1, gas2, ign})
      // the count restarts with the cause: lockout lands 2 clocks later, 1 for the air-open causes
      repeat (r.lim * TK - 1) @(posedge clk);
      #1 `CHK("early", 1'b0, lock)
    end
    wait_lock(r.lim > 0 ? 3 : 1);
    `CHK("type", r.code, ltype)
    `CHK("heat_ok", 1'b0, heat_ok)
    `CHK("gas_shut", 1'b0, gas1 | gas2 | ign)
    repeat (2) @(posedge clk);
    #1 `CHK("log0", r.code, log_t)
    clear_lock();
  endtask : run_row

  initial begin
    repeat (3) @(posedge clk);
    #1 `CHK("rst_lock", 1'b0, lock)
    `CHK("rst_heat", 1'b1, heat_ok)
    @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (rows[i]) run_row(rows[i]);
    // repeated flame loss in run: three recycles, then lockout
    drive(3'h6, 8'hf0);
    for (int k = 0; k < 4; k++) begin
      repeat (3) @(posedge clk);
      flame_cmd <= 1'b0;
      seen = 1'b0;
      repeat (6) begin
        @(posedge clk);
        #1 seen = seen | recyc;
      end
      `CHK("recycle", k < 3, seen)
      `CHK("loss_lock", k == 3, lock)
      @(posedge clk);
      flame_cmd <= 1'b1;
    end
    fault_cmd <= 4'h8;
    repeat (3) @(posedge clk);
    #1 `CHK("loss_type", 4'h4, ltype)
    clear_lock();
    // fan and second valve together; then count the lamp pulses
    drive(3'h0, 8'h09);
    repeat (3) @(posedge clk);
    #1 `CHK("priority", 4'h5, ltype)
    n = 0;
    prev = 1'b0;
    repeat (4000 * TK) begin
      @(posedge clk);
      #1 n += (led === 1'b1 && prev === 1'b0);
      prev = led;
    end
    `CHK("led_pulses", 5, n)
    clear_lock();
    // fourteen lockouts so far: walk the log, newest first
    for (int k = 0; k < 11; k++) begin
      @(posedge clk);
      sel <= 4'(k);
      e = (k == 0) ? 4'h5 : (k == 1) ? 4'h4 : 4'h0;
      if (k > 1 && k < 10) e = rows[13 - k].code;
      repeat (2) @(posedge clk);
      #1 `CHK("log", e, log_t)
    end
    // mid-run reset drops a standing lockout and empties the log
    drive(3'h0, 8'h01);
    repeat (3) @(posedge clk);
    #1 `CHK("pre_rst", 1'b1, lock)
    @(posedge clk);
    nrst      <= 1'b0;
    sel       <= 4'h0;
    fault_cmd <= 4'h0;
    repeat (2) @(posedge clk);
    #1 `CHK("rst_drop", 1'b0, lock)
    @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("rst_log", 4'h0, log_t)
    `CHK("rst_ok", 1'b1, heat_ok)
    stop_test();
  end
endmodule : tb_burner_lockout_monitor
